// >>> src/pid_consts.svh
// Offsets, field positions and reset values of the image decoder.
// Assumes inclusion by the package and the design file.
`ifndef PID_CONSTS_SVH
`define PID_CONSTS_SVH
`define PID_CFG_CS 8'h04
`define PID_CFG_BSM 8'h10
`define PID_OFS_CS 12'h004
`define PID_OFS_BSM 12'h010
`define PID_OFS_TCTL0 12'h100
`define PID_OFS_TADD0 12'h104
`define PID_OFS_TCTL1 12'h110
`define PID_OFS_TADD1 12'h114
`define PID_OFS_SCTL0 12'h200
`define PID_OFS_SAT0 12'h204
`define PID_OFS_SCTL1 12'h210
`define PID_OFS_SAT1 12'h214
`define PID_OFS_MISC2 12'h408
`define PID_CS_IOS 0
`define PID_CS_MS 1
`define PID_CS_BM 2
`define PID_CS_PEND 24
`define PID_CS_FULL 25
`define PID_TC_EN 31
`define PID_TC_WRITE_POST_ENABLE 30
`define PID_TC_READ_PREFETCH_ENABLE 29
`define PID_TC_BRST 28
`define PID_TC_INV 27
`define PID_TC_BS 20
`define PID_TC_PAS 16
`define PID_TC_TC 12
`define PID_TC_DSZ 8
`define PID_SC_WRITE_POST_ENABLE 31
`define PID_SC_PAS 30
`define PID_SC_READ_PREFETCH_ENABLE 29
`define PID_SA_BS 4
`define PID_SA_EN 0
`define PID_M2_BOC 31
`define PID_M2_B4 30
`define PID_M2_PC1 8
`define PID_M2_PC0 0
`define PID_RST_REG 32'h0000_0000
`endif

// >>> src/pid_pkg.sv
// Types shared by the image decoder and its FIFO.
// Assumes the constants header sits beside it.
`include "pid_consts.svh"
package pid_pkg;
  typedef enum logic [1:0] {PID_SP_MEM, PID_SP_IO, PID_SP_CFG} pid_space_t;
  typedef enum {PID_MS_IDLE, PID_MS_ISSUE, PID_MS_WAIT} pid_mst_state_t;
  typedef struct packed {
    pid_space_t space;
    logic [31:0] addr;
    logic write;
    logic [31:0] wdata;
    logic [3:0] be;
    logic burst;
  } pid_pci_req_t;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [31:0] data;
    logic [3:0] be;
    logic [3:0] tc;
    logic [1:0] dsize;
    logic burst;
    logic [5:0] prefetch;
    logic posted;
    logic image;
  } pid_lcl_req_t;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [31:0] wdata;
    logic [3:0] be;
  } pid_proc_req_t;
  typedef struct packed {
    logic [31:0] addr;
    logic io_space;
    logic write;
    logic [31:0] wdata;
    logic [3:0] be;
    logic burst;
    logic posted;
  } pid_mst_req_t;
endpackage

// >>> src/pid_bridge.sv
// Image decode and translation between a local processor and PCI.
// Assumes one clock, PCI and local sides already sequenced to ref_clk.
// Function
// - Posted slave writes complete locally first
// - Slave space bit picks memory or I/O
// - Slave prefetch bit makes PCI burst reads
// - Slave translation replaces upper PCI address bits
// - Slave block size sets both the decode compare and the replaced bits
// - No PCI mastering until bus master set
// - Config regs by config or memory cycles
// - Config regs answer straight after reset
// - Memory enable and image space gate memory
// - Registers in 4K window at base
// - I/O enable and image space gate I/O
// - Two independent PCI target images
// - Target image decodes only when enabled
// - Posted target writes finish on PCI first
// - Target prefetch uses per-channel prefetch counts
// - Target local burst needs image burst bit
// - Endian invert flips the global byte order
// - Target block size sets replaced address lines
// - Target space bit picks memory or I/O
// - Transfer code outputs follow image field
// - Destination size sets local cycle width
// - Target base compares, translated field forms address
// - Local bursts also need global four-beat enable
`timescale 1ns/1ns
`include "pid_consts.svh"

module pid_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_r];
  assign count = cnt_r;

  // Storage written at the write index
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // Pointers wrap because depth is a power of two
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

module pid_bridge (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic tgt_req_valid,
  output logic tgt_req_ready,
  input wire pid_pkg::pid_pci_req_t tgt_req,
  output logic tgt_claim,
  output logic tgt_rsp_valid,
  output logic [31:0] tgt_rsp_data,
  output logic lcl_valid,
  input wire logic lcl_ready,
  output pid_pkg::pid_lcl_req_t lcl_req,
  input wire logic lcl_done,
  input wire logic [31:0] lcl_rdata,
  input wire logic proc_req_valid,
  output logic proc_req_ready,
  input wire pid_pkg::pid_proc_req_t proc_req,
  output logic proc_rsp_valid,
  output logic proc_rsp_err,
  output logic [31:0] proc_rsp_data,
  output logic pci_mst_valid,
  input wire logic pci_mst_ready,
  output pid_pkg::pid_mst_req_t pci_mst_req,
  input wire logic pci_mst_done,
  input wire logic [31:0] pci_mst_rdata
);
  import pid_pkg::*;

  logic [31:0] cs_r, bsm_r, misc2_r;
  logic [31:0] tctl_r [2];
  logic [31:0] tadd_r [2];
  logic [31:0] sctl_r [2];
  logic [31:0] sat_r [2];
  logic [31:0] rd_val;
  logic [31:0] rsp_data_r;
  logic rsp_valid_r;
  logic tgt_pend_r;
  logic take;
  logic reg_hit;
  logic [11:0] reg_ofs;
  logic [1:0] img_hit;
  logic img_any;
  logic img_sel;
  logic fifo_in_ready;
  logic [2:0] fifo_count;
  pid_lcl_req_t push_req;
  logic bm, ms, io_space_enable;
  logic boc, burst4;
  logic swap, pend_swap_r;
  pid_mst_state_t mst_state_r;
  pid_mst_req_t mst_req_r;
  logic [1:0] s_hit;
  logic s_sel;
  logic p_rsp_r, p_err_r;
  logic [31:0] p_data_r;

  // Upper-address mask above the block size, 64K at code zero
  function automatic logic [15:0] blk_mask(input logic [3:0] bs);
    blk_mask = 16'hFFFF << bs;
  endfunction

  // Compare of upper bits above the block size
  function automatic logic blk_hit(input logic [15:0] a, input logic [15:0] base, input logic [3:0] bs);
    blk_hit = ((a ^ base) & blk_mask(bs)) == 16'h0000;
  endfunction

  // Replace bits above the block size, pass the lower ones
  function automatic logic [31:0] xlate(input logic [31:0] a, input logic [15:0] ta, input logic [3:0] bs);
    logic [15:0] m;
    m = blk_mask(bs);
    xlate = {(ta & m) | (a[31:16] & ~m), a[15:0]};
  endfunction

  // Byte-enable merge for register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) be_merge[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction

  // Full byte swap for the opposite byte order
  function automatic logic [31:0] bswap(input logic [31:0] d);
    bswap = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  assign bm = cs_r[`PID_CS_BM];
  assign ms = cs_r[`PID_CS_MS];
  assign io_space_enable = cs_r[`PID_CS_IOS];
  assign boc = misc2_r[`PID_M2_BOC];
  assign burst4 = misc2_r[`PID_M2_B4];
  // Byte order of the selected image, kept so a pending read answers in it
  assign swap = boc ^ tctl_r[img_sel][`PID_TC_INV];

  // Config cycles always reach the config pair; the window needs memory enable
  always_comb begin
    reg_hit = 1'b0;
    reg_ofs = 12'h000;
    if (tgt_req.space == PID_SP_CFG) begin
      reg_hit = (tgt_req.addr[7:0] == `PID_CFG_CS) || (tgt_req.addr[7:0] == `PID_CFG_BSM);
      reg_ofs = {4'h0, tgt_req.addr[7:0]};
    end else if (tgt_req.space == PID_SP_MEM && ms && tgt_req.addr[31:12] == bsm_r[31:12]) begin
      reg_hit = 1'b1;
      reg_ofs = tgt_req.addr[11:0];
    end
  end

  // Per-image target decode
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tgt
      logic sp_ok;
      assign sp_ok = tctl_r[gi][`PID_TC_PAS] ? (tgt_req.space == PID_SP_IO && io_space_enable)
                                             : (tgt_req.space == PID_SP_MEM && ms);
      assign img_hit[gi] = tctl_r[gi][`PID_TC_EN] && sp_ok && !reg_hit &&
                           blk_hit(tgt_req.addr[31:16], tadd_r[gi][31:16], tctl_r[gi][`PID_TC_BS +: 4]);
    end
  endgenerate

  // Image 0 wins if both overlap
  assign img_sel = !img_hit[0];
  assign img_any = |img_hit;
  assign tgt_claim = tgt_req_valid && (reg_hit || img_any);
  // Stall while a non-posted access waits, or an image access while the FIFO is full
  assign tgt_req_ready = !tgt_pend_r && !(img_any && !fifo_in_ready);
  assign take = tgt_req_valid && tgt_req_ready;

  // Local request built from the selected image
  always_comb begin
    logic [31:0] c;
    logic [31:0] a;
    c = tctl_r[img_sel];
    a = tadd_r[img_sel];
    push_req.addr = xlate(tgt_req.addr, a[15:0], c[`PID_TC_BS +: 4]);
    push_req.write = tgt_req.write;
    push_req.data = (boc ^ c[`PID_TC_INV]) ? bswap(tgt_req.wdata) : tgt_req.wdata;
    push_req.be = (boc ^ c[`PID_TC_INV]) ? {tgt_req.be[0], tgt_req.be[1], tgt_req.be[2], tgt_req.be[3]}
                                         : tgt_req.be;
    push_req.tc = c[`PID_TC_TC +: 4];
    push_req.dsize = c[`PID_TC_DSZ +: 2];
    push_req.burst = tgt_req.burst && c[`PID_TC_BRST] && burst4;
    push_req.prefetch = (c[`PID_TC_READ_PREFETCH_ENABLE] && !tgt_req.write && tgt_req.burst) ?
                        (img_sel ? misc2_r[`PID_M2_PC1 +: 6] : misc2_r[`PID_M2_PC0 +: 6]) : 6'h00;
    push_req.posted = tgt_req.write && c[`PID_TC_WRITE_POST_ENABLE];
    push_req.image = img_sel;
  end

  // Back-pressure from the local master reaches the PCI target ready
  pid_fifo #(.WIDTH($bits(pid_lcl_req_t)), .DEPTH(4)) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(take && img_any),
    .in_ready(fifo_in_ready),
    .in_data(push_req),
    .out_valid(lcl_valid),
    .out_ready(lcl_ready),
    .out_data(lcl_req),
    .count(fifo_count)
  );

  // Register read mux; unmapped offsets read zero
  always_comb begin
    case (reg_ofs)
      `PID_OFS_CS: rd_val = {6'h00, fifo_count == 3'd4, fifo_count != 3'd0, 21'h000000, cs_r[2:0]};
      `PID_OFS_BSM: rd_val = {bsm_r[31:12], 12'h000};
      `PID_OFS_TCTL0: rd_val = tctl_r[0];
      `PID_OFS_TADD0: rd_val = tadd_r[0];
      `PID_OFS_TCTL1: rd_val = tctl_r[1];
      `PID_OFS_TADD1: rd_val = tadd_r[1];
      `PID_OFS_SCTL0: rd_val = sctl_r[0];
      `PID_OFS_SAT0: rd_val = sat_r[0];
      `PID_OFS_SCTL1: rd_val = sctl_r[1];
      `PID_OFS_SAT1: rd_val = sat_r[1];
      `PID_OFS_MISC2: rd_val = misc2_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Register writes with byte enables
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cs_r <= `PID_RST_REG;
      bsm_r <= `PID_RST_REG;
      misc2_r <= `PID_RST_REG;
      for (int i = 0; i < 2; i++) begin
        tctl_r[i] <= `PID_RST_REG;
        tadd_r[i] <= `PID_RST_REG;
        sctl_r[i] <= `PID_RST_REG;
        sat_r[i] <= `PID_RST_REG;
      end
    end else if (take && reg_hit && tgt_req.write) begin
      case (reg_ofs)
        `PID_OFS_CS: cs_r <= be_merge(cs_r, tgt_req.wdata, tgt_req.be) & 32'h0000_0007;
        `PID_OFS_BSM: bsm_r <= be_merge(bsm_r, tgt_req.wdata, tgt_req.be) & 32'hFFFF_F000;
        `PID_OFS_TCTL0: tctl_r[0] <= be_merge(tctl_r[0], tgt_req.wdata, tgt_req.be);
        `PID_OFS_TADD0: tadd_r[0] <= be_merge(tadd_r[0], tgt_req.wdata, tgt_req.be);
        `PID_OFS_TCTL1: tctl_r[1] <= be_merge(tctl_r[1], tgt_req.wdata, tgt_req.be);
        `PID_OFS_TADD1: tadd_r[1] <= be_merge(tadd_r[1], tgt_req.wdata, tgt_req.be);
        `PID_OFS_SCTL0: sctl_r[0] <= be_merge(sctl_r[0], tgt_req.wdata, tgt_req.be);
        `PID_OFS_SAT0: sat_r[0] <= be_merge(sat_r[0], tgt_req.wdata, tgt_req.be);
        `PID_OFS_SCTL1: sctl_r[1] <= be_merge(sctl_r[1], tgt_req.wdata, tgt_req.be);
        `PID_OFS_SAT1: sat_r[1] <= be_merge(sat_r[1], tgt_req.wdata, tgt_req.be);
        `PID_OFS_MISC2: misc2_r <= be_merge(misc2_r, tgt_req.wdata, tgt_req.be);
        default: ;
      endcase
    end
  end

  // PCI-side answers: registers and posted writes at once, others on local done
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 32'h0000_0000;
      tgt_pend_r <= 1'b0;
      pend_swap_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      if (take && reg_hit) begin
        rsp_valid_r <= 1'b1;
        rsp_data_r <= tgt_req.write ? 32'h0000_0000 : rd_val;
      end else if (take && img_any) begin
        rsp_valid_r <= push_req.posted;
        rsp_data_r <= 32'h0000_0000;
        tgt_pend_r <= !push_req.posted;
        pend_swap_r <= swap;
      end else if (tgt_pend_r && lcl_done) begin
        rsp_valid_r <= 1'b1;
        rsp_data_r <= pend_swap_r ? bswap(lcl_rdata) : lcl_rdata;
        tgt_pend_r <= 1'b0;
      end
    end
  end

  assign tgt_rsp_valid = rsp_valid_r;
  assign tgt_rsp_data = rsp_data_r;

  // Slave image decode on the processor address
  generate
    for (gi = 0; gi < 2; gi++) begin : g_slv
      assign s_hit[gi] = blk_hit(proc_req.addr[31:16], sctl_r[gi][15:0], sat_r[gi][`PID_SA_BS +: 4]);
    end
  endgenerate
  assign s_sel = !s_hit[0];

  // Only one mastered PCI access at a time; a miss is answered with error
  assign proc_req_ready = (mst_state_r == PID_MS_IDLE);
  assign pci_mst_valid = (mst_state_r == PID_MS_ISSUE) && bm;

  // Slave channel sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mst_state_r <= PID_MS_IDLE;
      mst_req_r <= '0;
      p_rsp_r <= 1'b0;
      p_err_r <= 1'b0;
      p_data_r <= 32'h0000_0000;
    end else begin
      p_rsp_r <= 1'b0;
      case (mst_state_r)
        PID_MS_IDLE: begin
          if (proc_req_valid) begin
            if (!(|s_hit) || !bm) begin
              p_rsp_r <= 1'b1;
              p_err_r <= 1'b1;
              p_data_r <= 32'h0000_0000;
            end else begin
              mst_req_r.addr <= sat_r[s_sel][`PID_SA_EN] ?
                                xlate(proc_req.addr, sat_r[s_sel][31:16], sat_r[s_sel][`PID_SA_BS +: 4])
                                : proc_req.addr;
              mst_req_r.io_space <= sctl_r[s_sel][`PID_SC_PAS];
              mst_req_r.write <= proc_req.write;
              mst_req_r.wdata <= proc_req.wdata;
              mst_req_r.be <= proc_req.be;
              mst_req_r.burst <= !proc_req.write && sctl_r[s_sel][`PID_SC_READ_PREFETCH_ENABLE];
              mst_req_r.posted <= proc_req.write && sctl_r[s_sel][`PID_SC_WRITE_POST_ENABLE];
              // Posted write finishes on the local side right away
              p_rsp_r <= proc_req.write && sctl_r[s_sel][`PID_SC_WRITE_POST_ENABLE];
              p_err_r <= 1'b0;
              p_data_r <= 32'h0000_0000;
              mst_state_r <= PID_MS_ISSUE;
            end
          end
        end
        PID_MS_ISSUE: begin
          if (pci_mst_valid && pci_mst_ready) begin
            mst_state_r <= mst_req_r.posted ? PID_MS_IDLE : PID_MS_WAIT;
          end
        end
        PID_MS_WAIT: begin
          if (pci_mst_done) begin
            p_rsp_r <= 1'b1;
            p_err_r <= 1'b0;
            p_data_r <= mst_req_r.write ? 32'h0000_0000 : pci_mst_rdata;
            mst_state_r <= PID_MS_IDLE;
          end
        end
        default: mst_state_r <= PID_MS_IDLE;
      endcase
    end
  end

  assign pci_mst_req = mst_req_r;
  assign proc_rsp_valid = p_rsp_r;
  assign proc_rsp_err = p_err_r;
  assign proc_rsp_data = p_data_r;
endmodule

// >>> test/pid_bridge_monitor.sv
// Port checker for the image decoder.
// Assumes the bind below attaches it to every pid_bridge.
`timescale 1ns/1ns
module pid_bridge_monitor (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic tgt_req_valid,
  input wire logic tgt_req_ready,
  input wire pid_pkg::pid_pci_req_t tgt_req,
  input wire logic tgt_claim,
  input wire logic tgt_rsp_valid,
  input wire logic lcl_valid,
  input wire logic lcl_ready,
  input wire pid_pkg::pid_lcl_req_t lcl_req,
  input wire logic lcl_done,
  input wire logic proc_rsp_valid,
  input wire logic proc_rsp_err,
  input wire logic [31:0] proc_rsp_data,
  input wire logic pci_mst_valid,
  input wire logic pci_mst_ready,
  input wire pid_pkg::pid_mst_req_t pci_mst_req,
  input wire logic pci_mst_done,
  input wire logic [31:0] pci_mst_rdata
);
  import pid_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // Access taken, and a config register offset
  sequence s_taken;
    tgt_req_valid && tgt_req_ready;
  endsequence
  sequence s_cfg_reg;
    tgt_req.space == PID_SP_CFG && (tgt_req.addr == 32'h0000_0004 || tgt_req.addr == 32'h0000_0010);
  endsequence
  a_unclaimed_silent: assert property (s_taken ##0 !tgt_claim |=> !tgt_rsp_valid)
    else $error("unclaimed access answered");
  a_cfg_reg_answer: assert property (s_taken ##0 s_cfg_reg |-> tgt_claim ##1 tgt_rsp_valid)
    else $error("config register not answered");
  a_cfg_no_device: assert property (tgt_req_valid && tgt_req.space == PID_SP_CFG && tgt_req.addr[11:8] != 4'h0
    |-> !tgt_claim)
    else $error("device register claimed by config cycle");
  a_claim_answer: assert property (s_taken ##0 tgt_claim |=> tgt_rsp_valid || !tgt_req_ready)
    else $error("claimed access neither answered nor pending");
  a_local_done_answer: assert property (lcl_done |=> tgt_rsp_valid)
    else $error("local completion not answered");
  a_err_no_master: assert property (proc_rsp_valid && proc_rsp_err |-> !pci_mst_valid)
    else $error("refused processor access still mastered");
  a_master_hold: assert property (pci_mst_valid && !pci_mst_ready |=> $stable(pci_mst_req))
    else $error("master request changed while waiting");
  a_local_hold: assert property (lcl_valid && !lcl_ready |=> lcl_valid && $stable(lcl_req))
    else $error("local head changed while stalled");
  a_master_done_data: assert property (pci_mst_done |=> proc_rsp_valid && !proc_rsp_err
    && proc_rsp_data == ($past(pci_mst_req.write) ? 32'h0000_0000 : $past(pci_mst_rdata)))
    else $error("read data not returned to processor");
endmodule
bind pid_bridge pid_bridge_monitor u_mon (.*);

// >>> test/pid_far_model.sv
// Far side model: local memory and PCI target, logging each request.
// Assumes the bench drives stall and reads the queues.
`timescale 1ns/1ns
module pid_far_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic stall,
  input wire logic lcl_valid,
  output logic lcl_ready,
  input wire pid_pkg::pid_lcl_req_t lcl_req,
  output logic lcl_done,
  output logic [31:0] lcl_rdata,
  input wire logic pci_mst_valid,
  output logic pci_mst_ready,
  input wire pid_pkg::pid_mst_req_t pci_mst_req,
  output logic pci_mst_done,
  output logic [31:0] pci_mst_rdata
);
  import pid_pkg::*;
  pid_lcl_req_t lcl_q[$];
  pid_mst_req_t mst_q[$];
  logic [31:0] lval_r;
  logic [31:0] mval_r;
  logic go_r;
  // Stall holds the head; PCI side always makes the master wait a cycle
  assign lcl_ready = !stall;
  assign pci_mst_ready = go_r;
  // Idle data lines show the inverse, so stale data cannot pass
  assign lcl_rdata = lcl_done ? lval_r : ~lval_r;
  assign pci_mst_rdata = pci_mst_done ? mval_r : ~mval_r;
  // Non-posted requests complete the cycle after they are taken
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lcl_done <= 1'b0;
      pci_mst_done <= 1'b0;
      go_r <= 1'b0;
      lval_r <= 32'h0000_0000;
      mval_r <= 32'h0000_0000;
    end else begin
      go_r <= pci_mst_valid && !go_r;
      lcl_done <= lcl_valid && lcl_ready && !(lcl_req.write && lcl_req.posted);
      pci_mst_done <= pci_mst_valid && go_r && !(pci_mst_req.write && pci_mst_req.posted);
      if (lcl_valid && lcl_ready) begin
        lval_r <= lcl_req.addr ^ 32'h5A5A_0000;
        lcl_q.push_back(lcl_req);
      end
      if (pci_mst_valid && go_r) begin
        mval_r <= pci_mst_req.addr ^ 32'h5A5A_0000;
        mst_q.push_back(pci_mst_req);
      end
    end
  end
endmodule

// >>> test/tb_top.sv
// Self-checking bench: PCI side access tasks, processor tasks, far model.
// Assumes the monitor is bound to the design instance.
`timescale 1ns/1ns
`include "pid_consts.svh"
module tb_top;
  import pid_pkg::*;
  localparam logic [31:0] WBASE = 32'h8000_0000;
  localparam logic [31:0] NONE = 32'hFFFF_FFFF;
  logic ref_clk, nrst, stall, tgt_req_valid, tgt_req_ready, tgt_claim, tgt_rsp_valid, c, t_burst;
  logic lcl_valid, lcl_ready, lcl_done, proc_req_valid, proc_req_ready, proc_rsp_valid, proc_rsp_err;
  logic pci_mst_valid, pci_mst_ready, pci_mst_done;
  logic [31:0] tgt_rsp_data, lcl_rdata, proc_rsp_data, pci_mst_rdata, r;
  logic [3:0] t_be;
  pid_pci_req_t tgt_req;
  pid_lcl_req_t lcl_req, lq;
  pid_proc_req_t proc_req;
  pid_mst_req_t pci_mst_req, mq;
  int failures, check_count, n;
  pid_bridge uut (.ref_clk(ref_clk), .nrst(nrst), .tgt_req_valid(tgt_req_valid), .tgt_req_ready(tgt_req_ready),
    .tgt_req(tgt_req), .tgt_claim(tgt_claim), .tgt_rsp_valid(tgt_rsp_valid), .tgt_rsp_data(tgt_rsp_data),
    .lcl_valid(lcl_valid), .lcl_ready(lcl_ready), .lcl_req(lcl_req), .lcl_done(lcl_done), .lcl_rdata(lcl_rdata),
    .proc_req_valid(proc_req_valid), .proc_req_ready(proc_req_ready), .proc_req(proc_req),
    .proc_rsp_valid(proc_rsp_valid), .proc_rsp_err(proc_rsp_err), .proc_rsp_data(proc_rsp_data),
    .pci_mst_valid(pci_mst_valid), .pci_mst_ready(pci_mst_ready), .pci_mst_req(pci_mst_req),
    .pci_mst_done(pci_mst_done), .pci_mst_rdata(pci_mst_rdata));
  pid_far_model far (.ref_clk(ref_clk), .nrst(nrst), .stall(stall), .lcl_valid(lcl_valid), .lcl_ready(lcl_ready),
    .lcl_req(lcl_req), .lcl_done(lcl_done), .lcl_rdata(lcl_rdata), .pci_mst_valid(pci_mst_valid),
    .pci_mst_ready(pci_mst_ready), .pci_mst_req(pci_mst_req), .pci_mst_done(pci_mst_done),
    .pci_mst_rdata(pci_mst_rdata));
  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One cycle; a wait that runs too long ends the run
  task automatic step(inout int k);
    @(posedge ref_clk);
    #1;
    k++;
    if (k > 40) begin
      failures++;
      test_done();
    end
  endtask
  // PCI side access; no answer within 12 cycles returns NONE
  task automatic tgt_acc(input pid_space_t sp, input logic [31:0] a, input logic w, input logic [31:0] d);
    int k;
    logic rdy;
    tgt_req = '{space: sp, addr: a, write: w, wdata: d, be: t_be, burst: t_burst};
    tgt_req_valid = 1'b1;
    rdy = 1'b0;
    k = 0;
    while (!rdy) begin
      #1;
      rdy = tgt_req_ready;
      c = tgt_claim;
      step(k);
    end
    tgt_req_valid = 1'b0;
    for (k = 0; k < 12 && tgt_rsp_valid !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    r = (tgt_rsp_valid === 1'b1) ? tgt_rsp_data : NONE;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rdc(input pid_space_t sp, input logic [31:0] a, input logic ce, input logic [31:0] exp);
    tgt_acc(sp, a, 1'b0, 32'h0000_0000);
    chk(c, ce);
    chk(r, exp);
  endtask
  task automatic wr(input logic [11:0] o, input logic [31:0] d);
    tgt_acc(PID_SP_MEM, WBASE | o, 1'b1, d);
    chk(c, 1'b1);
  endtask
  // Processor access: wait idle, then the answer
  task automatic proc_acc(input logic [31:0] a, input logic w, input logic ee, input logic [31:0] ed);
    int k;
    proc_req = '{addr: a, write: w, wdata: 32'h1234_5678, be: 4'hF};
    proc_req_valid = 1'b1;
    k = 0;
    while (proc_req_ready !== 1'b1) step(k);
    step(k);
    proc_req_valid = 1'b0;
    while (proc_rsp_valid !== 1'b1) step(k);
    chk(proc_rsp_err, ee);
    if (!w && !ee) chk(proc_rsp_data, ed);
    step(k);
  endtask
  task automatic mst_pop();
    int k;
    k = 0;
    while (far.mst_q.size() == 0) step(k);
    mq = far.mst_q.pop_front();
  endtask
  task automatic lcl_pop();
    int k;
    k = 0;
    while (far.lcl_q.size() == 0) step(k);
    lq = far.lcl_q.pop_front();
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    {nrst, stall, tgt_req_valid, proc_req_valid, t_burst, failures, check_count} = '0;
    tgt_req = '0;
    proc_req = '0;
    t_be = 4'hF;
    repeat (20) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    // Config registers answer at once; memory space still off
    rdc(PID_SP_CFG, 32'h4, 1'b1, 32'h0);
    rdc(PID_SP_CFG, 32'h10, 1'b1, 32'h0);
    rdc(PID_SP_MEM, 32'h4, 1'b0, NONE);
    tgt_acc(PID_SP_CFG, 32'h10, 1'b1, WBASE);
    tgt_acc(PID_SP_CFG, 32'h4, 1'b1, 32'h0300_0003);
    // Window decode; status bits are read only
    rdc(PID_SP_MEM, WBASE | 32'h4, 1'b1, 32'h3);
    rdc(PID_SP_MEM, WBASE | 32'h1004, 1'b0, NONE);
    rdc(PID_SP_CFG, 32'h100, 1'b0, NONE);
    rdc(PID_SP_MEM, WBASE | 32'h300, 1'b1, 32'h0);
    rdc(PID_SP_MEM, WBASE | 32'h100, 1'b1, 32'h0);
    // Slave images: bus master gating, posting, translation, space, prefetch
    wr(`PID_OFS_SCTL0, 32'h8000_1000);
    wr(`PID_OFS_SAT0, 32'hA000_0011);
    wr(`PID_OFS_SCTL1, 32'h6000_2000);
    wr(`PID_OFS_SAT1, 32'h0000_0040);
    proc_acc(32'h1001_2344, 1'b1, 1'b1, 32'h0);
    chk(far.mst_q.size(), 0);
    wr(`PID_OFS_CS, 32'h7);
    proc_acc(32'h1001_2344, 1'b1, 1'b0, 32'h0);
    chk(far.mst_q.size(), 0);
    mst_pop();
    chk(mq.addr, 32'hA001_2344);
    chk({mq.io_space, mq.write, mq.posted}, 3'b011);
    proc_acc(32'h2003_0010, 1'b0, 1'b0, 32'h2003_0010 ^ 32'h5A5A_0000);
    mst_pop();
    chk(mq.addr, 32'h2003_0010);
    chk({mq.io_space, mq.burst}, 2'b11);
    proc_acc(32'h1002_0000, 1'b0, 1'b1, 32'h0);
    // Target image 0: posted memory write with translation
    wr(`PID_OFS_TADD0, 32'h4000_0600);
    wr(`PID_OFS_TCTL0, 32'hC020_5200);
    tgt_acc(PID_SP_MEM, 32'h4003_1234, 1'b1, 32'hCAFE_0001);
    chk(c, 1'b1);
    chk(r, 32'h0);
    lcl_pop();
    chk(lq.addr, 32'h0603_1234);
    chk({lq.tc, lq.dsize, lq.posted, lq.image}, {4'h5, 2'h2, 2'b10});
    chk(lq.data, 32'hCAFE_0001);
    // Target image 1: I/O burst read, prefetch, endian invert
    wr(`PID_OFS_TADD1, 32'h5000_0700);
    wr(`PID_OFS_TCTL1, 32'hB801_A100);
    wr(`PID_OFS_MISC2, 32'h4000_1500);
    t_burst = 1'b1;
    t_be = 4'h3;
    rdc(PID_SP_IO, 32'h5000_0040, 1'b1, 32'h4000_5A5D);
    lcl_pop();
    chk(lq.addr, 32'h0700_0040);
    chk({lq.burst, lq.prefetch, lq.tc, lq.dsize}, {1'b1, 6'h15, 4'hA, 2'h1});
    chk({lq.be, lq.image, lq.posted}, {4'hC, 2'b10});
    t_burst = 1'b0;
    t_be = 4'hF;
    // Space and enable gating
    rdc(PID_SP_MEM, 32'h5000_0040, 1'b0, NONE);
    wr(`PID_OFS_CS, 32'h6);
    rdc(PID_SP_IO, 32'h5000_0040, 1'b0, NONE);
    wr(`PID_OFS_TCTL0, 32'h4020_5200);
    rdc(PID_SP_MEM, 32'h4000_0000, 1'b0, NONE);
    wr(`PID_OFS_TCTL0, 32'hC020_5200);
    // Fill the FIFO with the local side stalled, then drain in order
    stall = 1'b1;
    for (int i = 0; i < 4; i++) tgt_acc(PID_SP_MEM, 32'h4000_0010 + 4 * i, 1'b1, i);
    rdc(PID_SP_MEM, WBASE | 32'h4, 1'b1, 32'h0300_0006);
    tgt_req = '{space: PID_SP_MEM, addr: 32'h4000_0020, write: 1'b1, wdata: 32'h4, be: 4'hF, burst: 1'b0};
    tgt_req_valid = 1'b1;
    #1;
    chk(tgt_req_ready, 1'b0);
    @(posedge ref_clk);
    #1;
    chk(tgt_req_ready, 1'b0);
    // Refused request stays offered until the drain frees a slot
    stall = 1'b0;
    tgt_acc(PID_SP_MEM, 32'h4000_0020, 1'b1, 32'h4);
    chk(c, 1'b1);
    for (int i = 0; i < 5; i++) begin
      lcl_pop();
      chk(lq.addr, 32'h0600_0010 + 4 * i);
      chk(lq.data, 32'(i));
    end
    chk(far.lcl_q.size(), 0);
    test_done();
  end
endmodule
